// ==== clk_sel_defines.svh ====
// Offsets, field positions, reset values and timing figures of the switching clock select.
`ifndef CLK_SEL_DEFINES_SVH
`define CLK_SEL_DEFINES_SVH
`define PCLK_NS        100
`define PCLK_KHZ       10000
`define SYS_KHZ        8000
`define N_MIN          6
`define N_MAX          40
`define REQ_MIN_KHZ    200
`define REQ_MAX_KHZ    1333
`define F_LOW_KHZ      200
`define F_OPEN_KHZ     400
`define F_HIGH_KHZ     1000
`define F_OUT_KHZ      400
`define EXT_MIN_PER_NS 714
`define EXT_MAX_PER_NS 5000
`define DET_WIN_NS     20000
`define LOSS_NS        10000
`define LOCK_EDGES     3
`define START_CYC      4
`define RES_ENTRIES    19
`define REG_CTRL       8'h00
`define REG_FSET       8'h04
`define REG_STAT       8'h08
`define REG_FRB        8'h0c
`define CTRL_PROG_BIT  0
`define FSET_RESET     16'h0190
`define STAT_MODE_LSB  0
`define STAT_STATE_LSB 2
`define STAT_TAKEN_BIT 5
`define STAT_LEVEL_BIT 6
`define FRB_PER_LSB    0
`define FRB_N_LSB      8
`define FRB_KHZ_LSB    16
`endif

// ==== clk_sel_pkg.sv ====
// Types and shared arithmetic of the switching clock select.
`include "clk_sel_defines.svh"
package clk_sel_pkg;
    typedef enum logic [2:0] {
        ST_OFF      = 3'h0,
        ST_DETECT   = 3'h1,
        ST_LOCKED   = 3'h3,
        ST_INTERNAL = 3'h2,
        ST_HOLD     = 3'h6
    } sel_state_t;
    typedef enum logic [1:0] {
        MODE_AUTO   = 2'h0,
        MODE_INPUT  = 2'h1,
        MODE_OUTPUT = 2'h2
    } sync_mode_t;
    // Converts kHz to pclk cycles and back, rounded; zero gives all ones.
    function automatic logic [15:0] recip_pclk(input logic [15:0] v);
        logic [16:0] q;
        q = 17'h0;
        if (v == 16'h0)
            return 16'hffff;
        q = (17'(`PCLK_KHZ) + 17'(v >> 1)) / 17'(v);
        return q[15:0];
    endfunction
endpackage

// ==== sync_edge_meter.sv ====
// Synchroniser, rising edge finder and edge spacing meter for the sync pin.
`timescale 1ns/1ps
`default_nettype none
module sync_edge_meter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pin,
    output logic            level,
    output logic            rise,
    output logic [7:0]      period,
    output logic [7:0]      since
);
    logic       s1_q, s2_q, s3_q;
    logic [7:0] since_q, since_d, period_q, period_d;

    assign level  = s2_q;
    assign rise   = s2_q & ~s3_q;
    assign period = period_q;
    assign since  = since_q;

    // The spacing saturates so a stopped clock reads as a long, not a short, period.
    always_comb
    begin
        since_d  = (since_q == 8'hff) ? since_q : since_q + 8'h01;
        period_d = period_q;
        if (rise)
        begin
            since_d  = 8'h00;
            period_d = (since_q == 8'hff) ? since_q : since_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q     <= 1'b0;
            s2_q     <= 1'b0;
            s3_q     <= 1'b0;
            since_q  <= 8'hff;
            period_q <= 8'hff;
        end
        else
        begin
            s1_q     <= pin;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            since_q  <= since_d;
            period_q <= period_d;
        end
    end
endmodule
`default_nettype wire

// ==== freq_lut.sv ====
// Resistor lookup and nearest 8 MHz divisor for a programmed frequency.
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_defines.svh"
module freq_lut (
    input  wire logic [4:0]  res_code,
    input  wire logic [15:0] req_khz,
    output logic [7:0]       res_period,
    output logic [5:0]       prog_n,
    output logic [7:0]       prog_period
);
    localparam logic [15:0] RES_KHZ [`RES_ENTRIES] = '{
        16'd200, 16'd222, 16'd242, 16'd267, 16'd296, 16'd320, 16'd364,
        16'd400, 16'd421, 16'd471, 16'd533, 16'd571, 16'd615, 16'd727,
        16'd800, 16'd889, 16'd1000, 16'd1143, 16'd1333};

    logic [15:0] k, n_lo, n_hi, f_lo, f_hi, r;
    logic [31:0] p;

    // Codes past the table end clamp to its top entry.
    always_comb
    begin
        r = (res_code >= 5'(`RES_ENTRIES)) ? RES_KHZ[`RES_ENTRIES-1] : RES_KHZ[res_code];
        res_period = 8'(clk_sel_pkg::recip_pclk(r));
        k = req_khz;
        if (k < 16'(`REQ_MIN_KHZ))
            k = 16'(`REQ_MIN_KHZ);
        if (k > 16'(`REQ_MAX_KHZ))
            k = 16'(`REQ_MAX_KHZ);
        n_lo = 16'(`SYS_KHZ) / k;
        if (n_lo < 16'(`N_MIN))
            n_lo = 16'(`N_MIN);
        if (n_lo > 16'(`N_MAX))
            n_lo = 16'(`N_MAX);
        n_hi = (n_lo == 16'(`N_MAX)) ? n_lo : n_lo + 16'h1;
        f_lo = 16'(`SYS_KHZ) / n_lo;
        f_hi = 16'(`SYS_KHZ) / n_hi;
        // Nearest achievable frequency wins; a tie takes the higher one.
        if (f_lo >= k && (f_lo - k) > (k - f_hi))
            prog_n = n_hi[5:0];
        else
            prog_n = n_lo[5:0];
        p = (32'(prog_n) * 32'(`PCLK_KHZ) + 32'(`SYS_KHZ / 2)) / 32'(`SYS_KHZ);
        prog_period = p[7:0];
    end
endmodule
`default_nettype wire

// ==== switching_clock_select.sv ====
// Switching clock source selection, sync pin handling and APB registers.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_defines.svh"
module switching_clock_select (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        en_pin,
    input  wire logic        cfg_high_sense,
    input  wire logic        cfg_low_sense,
    input  wire logic        sync_high_sense,
    input  wire logic        sync_low_sense,
    input  wire logic        sync_res_sense,
    input  wire logic [4:0]  sync_res_code,
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe,
    output logic             sw_clk,
    output logic             freq_locked
);
    // Derived counts; a short tolerance absorbs the two-flop sampling jitter.
    localparam int MIN_PER  = (`EXT_MIN_PER_NS + `PCLK_NS - 1) / `PCLK_NS - 1;
    localparam int MAX_PER  = `EXT_MAX_PER_NS / `PCLK_NS + 1;
    localparam int DET_CYC  = `DET_WIN_NS / `PCLK_NS;
    localparam int LOSS_CYC = `LOSS_NS / `PCLK_NS;
    logic [10:0] pin_s1_q, pin_s2_q;
    logic        en_s, cfg_h_s, cfg_l_s, syn_h_s, syn_l_s, res_s, level, rise;
    logic [4:0]  code_s;
    logic [5:0]  prog_n;
    clk_sel_pkg::sel_state_t state_q, state_d;
    clk_sel_pkg::sync_mode_t mode_q, mode_d;
    logic [2:0]  start_q, start_d;
    logic        taken_q, taken_d, ctrl_prog_q, ctrl_prog_d;
    logic [1:0]  good_q, good_d;
    logic [7:0]  period, since, res_period, prog_period, win_q, win_d;
    logic [7:0]  static_per_q, static_per_d, lock_per_q, lock_per_d, hold_per_q, hold_per_d;
    logic [7:0]  phase_q, phase_d, int_per;
    logic        sw_clk_d, sync_out_d, sync_oe_d, locked_d, osc;
    logic [15:0] fset_q, fset_d;
    logic [31:0] prdata_d, rd_val;
    logic        pready_d, pslverr_d, access, mapped;
    assign {en_s, cfg_h_s, cfg_l_s, syn_h_s, syn_l_s, res_s, code_s} = pin_s2_q;
    sync_edge_meter u_meter (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (sync_in),
        .level   (level),
        .rise    (rise),
        .period  (period),
        .since   (since)
    );
    freq_lut u_lut (
        .res_code    (code_s),
        .req_khz     (fset_q),
        .res_period  (res_period),
        .prog_n      (prog_n),
        .prog_period (prog_period)
    );
    function automatic logic in_range(input logic [7:0] p);
        return (p >= 8'(MIN_PER)) && (p <= 8'(MAX_PER));
    endfunction
    // Straps and static sync level are caught once after reset release.
    always_comb
    begin
        start_d      = start_q;
        taken_d      = taken_q;
        mode_d       = mode_q;
        static_per_d = static_per_q;
        if (!taken_q)
        begin
            start_d = start_q + 3'h1;
            if (start_q == 3'(`START_CYC))
            begin
                taken_d = 1'b1;
                mode_d = cfg_h_s ? clk_sel_pkg::MODE_OUTPUT :
                         cfg_l_s ? clk_sel_pkg::MODE_INPUT :
                         clk_sel_pkg::MODE_AUTO;
                if (cfg_h_s || cfg_l_s)
                    static_per_d = 8'(clk_sel_pkg::recip_pclk(16'(`F_OUT_KHZ)));
                else if (res_s)
                    static_per_d = res_period;
                else if (syn_h_s)
                    static_per_d = 8'(clk_sel_pkg::recip_pclk(16'(`F_HIGH_KHZ)));
                else if (syn_l_s)
                    static_per_d = 8'(clk_sel_pkg::recip_pclk(16'(`F_LOW_KHZ)));
                else
                    static_per_d = 8'(clk_sel_pkg::recip_pclk(16'(`F_OPEN_KHZ)));
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_q     <= 11'h000;
            pin_s2_q     <= 11'h000;
            start_q      <= 3'h0;
            taken_q      <= 1'b0;
            mode_q       <= clk_sel_pkg::MODE_AUTO;
            static_per_q <= 8'h00;
        end
        else
        begin
            pin_s1_q     <= {en_pin, cfg_high_sense, cfg_low_sense, sync_high_sense,
                             sync_low_sense, sync_res_sense, sync_res_code};
            pin_s2_q     <= pin_s1_q;
            start_q      <= start_d;
            taken_q      <= taken_d;
            mode_q       <= mode_d;
            static_per_q <= static_per_d;
        end
    end
    // Source selection: detect, lock, internal, or holdover after a loss.
    always_comb
    begin
        state_d    = state_q;
        win_d      = win_q;
        good_d     = good_q;
        lock_per_d = lock_per_q;
        hold_per_d = hold_per_q;
        unique case (state_q)
            clk_sel_pkg::ST_OFF:
                if (taken_q && en_s)
                begin
                    win_d  = 8'h00;
                    good_d = 2'h0;
                    if (mode_q == clk_sel_pkg::MODE_OUTPUT)
                        state_d = clk_sel_pkg::ST_INTERNAL;
                    else
                        state_d = clk_sel_pkg::ST_DETECT;
                end
            clk_sel_pkg::ST_DETECT:
                if (!en_s)
                    state_d = clk_sel_pkg::ST_OFF;
                else
                begin
                    win_d = win_q + 8'h01;
                    if (rise)
                        good_d = in_range(period) ? good_q + 2'h1 : 2'h0;
                    if (rise && in_range(period) && good_q == 2'(`LOCK_EDGES - 1))
                    begin
                        state_d    = clk_sel_pkg::ST_LOCKED;
                        lock_per_d = period;
                    end
                    else if (win_q == 8'(DET_CYC - 1))
                        state_d = clk_sel_pkg::ST_INTERNAL;
                end
            clk_sel_pkg::ST_LOCKED:
                if (!en_s)
                    state_d = clk_sel_pkg::ST_OFF;
                else if (since >= 8'(LOSS_CYC) || (rise && !in_range(period)))
                begin
                    state_d    = clk_sel_pkg::ST_HOLD;
                    hold_per_d = lock_per_q;
                end
                else if (rise)
                    lock_per_d = period;
            clk_sel_pkg::ST_INTERNAL,
            clk_sel_pkg::ST_HOLD:
                if (!en_s)
                    state_d = clk_sel_pkg::ST_OFF;
            default:
                state_d = clk_sel_pkg::ST_OFF;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= clk_sel_pkg::ST_OFF;
            win_q      <= 8'h00;
            good_q     <= 2'h0;
            lock_per_q <= 8'h00;
            hold_per_q <= 8'h00;
        end
        else
        begin
            state_q    <= state_d;
            win_q      <= win_d;
            good_q     <= good_d;
            lock_per_q <= lock_per_d;
            hold_per_q <= hold_per_d;
        end
    end
    // Oscillator; in output mode it runs from start-up so followers can lock early.
    always_comb
    begin
        int_per = (state_q == clk_sel_pkg::ST_LOCKED) ? lock_per_q :
                  (state_q == clk_sel_pkg::ST_HOLD) ? hold_per_q :
                  (mode_q == clk_sel_pkg::MODE_OUTPUT) ?
                  8'(clk_sel_pkg::recip_pclk(16'(`F_OUT_KHZ))) :
                  ctrl_prog_q ? prog_period : static_per_q;
        phase_d = (phase_q + 8'h01 >= int_per) ? 8'h00 : phase_q + 8'h01;
        if (state_q == clk_sel_pkg::ST_LOCKED && rise)
            phase_d = 8'h00;
        if (!taken_q || (state_q == clk_sel_pkg::ST_OFF &&
                         mode_q != clk_sel_pkg::MODE_OUTPUT))
            phase_d = 8'h00;
        osc        = phase_d < {1'b0, int_per[7:1]};
        sw_clk_d   = osc && state_q != clk_sel_pkg::ST_OFF &&
                     state_q != clk_sel_pkg::ST_DETECT;
        sync_oe_d  = taken_q && mode_q == clk_sel_pkg::MODE_OUTPUT;
        sync_out_d = osc && sync_oe_d;
        locked_d   = state_d == clk_sel_pkg::ST_LOCKED;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_q     <= 8'h00;
            sw_clk      <= 1'b0;
            sync_out    <= 1'b0;
            sync_oe     <= 1'b0;
            freq_locked <= 1'b0;
        end
        else
        begin
            phase_q     <= phase_d;
            sw_clk      <= sw_clk_d;
            sync_out    <= sync_out_d;
            sync_oe     <= sync_oe_d;
            freq_locked <= locked_d;
        end
    end
    // APB slave with one wait state, so every answer comes from a flop.
    always_comb
    begin
        access      = psel && penable && !pready;
        mapped      = paddr == `REG_CTRL || paddr == `REG_FSET ||
                      paddr == `REG_STAT || paddr == `REG_FRB;
        ctrl_prog_d = ctrl_prog_q;
        fset_d      = fset_q;
        rd_val      = 32'h0;
        unique case (paddr)
            `REG_CTRL: rd_val[`CTRL_PROG_BIT] = ctrl_prog_q;
            `REG_FSET: rd_val[15:0] = fset_q;
            `REG_STAT:
            begin
                rd_val[`STAT_MODE_LSB +: 2]  = mode_q;
                rd_val[`STAT_STATE_LSB +: 3] = state_q;
                rd_val[`STAT_TAKEN_BIT]      = taken_q;
                rd_val[`STAT_LEVEL_BIT]      = level;
            end
            `REG_FRB:
            begin
                rd_val[`FRB_PER_LSB +: 8] = int_per;
                rd_val[`FRB_N_LSB +: 6]   = prog_n;
                rd_val[`FRB_KHZ_LSB +: 16] = clk_sel_pkg::recip_pclk(16'(int_per));
            end
            default: rd_val = 32'h0;
        endcase
        if (psel && penable && pready && pwrite && paddr == `REG_CTRL)
            ctrl_prog_d = pwdata[`CTRL_PROG_BIT];
        if (psel && penable && pready && pwrite && paddr == `REG_FSET)
            fset_d = pwdata[15:0];
        pready_d  = access;
        pslverr_d = access && !mapped;
        prdata_d  = (access && !pwrite) ? rd_val : 32'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_prog_q <= 1'b0;
            fset_q      <= `FSET_RESET;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h0;
        end
        else
        begin
            ctrl_prog_q <= ctrl_prog_d;
            fset_q      <= fset_d;
            pready      <= pready_d;
            pslverr     <= pslverr_d;
            prdata      <= prdata_d;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_strap_open_auto: assert property ($rose(taken_q) && !$past(cfg_h_s) && !$past(cfg_l_s)
        |-> mode_q == clk_sel_pkg::MODE_AUTO) else $error("open strap not auto");
    a_enable_detect: assert property (state_q == clk_sel_pkg::ST_OFF && taken_q && en_s &&
        mode_q != clk_sel_pkg::MODE_OUTPUT |=> state_q == clk_sel_pkg::ST_DETECT)
        else $error("no detect after enable");
    a_edge_align: assert property (state_q == clk_sel_pkg::ST_LOCKED && en_s && rise &&
        in_range(period) && since < 8'(LOSS_CYC) |=> phase_q == 8'h00)
        else $error("cycle not aligned to edge");
    a_static_high: assert property ($rose(taken_q) && mode_q == clk_sel_pkg::MODE_AUTO &&
        !$past(res_s) && $past(syn_h_s) |-> static_per_q == 8'h0a)
        else $error("high level not 1 MHz");
    a_static_hold: assert property (taken_q && $past(taken_q) |-> $stable(static_per_q))
        else $error("static setting changed");
    a_res_table: assert property ($rose(taken_q) && mode_q == clk_sel_pkg::MODE_AUTO &&
        $past(res_s) && $past(code_s) == 5'h00 |-> static_per_q == 8'h32)
        else $error("resistor table wrong");
    a_divisor_span: assert property (prog_n >= 6'(`N_MIN) && prog_n <= 6'(`N_MAX))
        else $error("divisor out of span");
    a_out_no_lock: assert property (mode_q == clk_sel_pkg::MODE_OUTPUT
        |-> state_q != clk_sel_pkg::ST_LOCKED && state_q != clk_sel_pkg::ST_DETECT)
        else $error("output mode detecting");
    a_out_drive: assert property (taken_q && mode_q == clk_sel_pkg::MODE_OUTPUT
        |=> sync_oe) else $error("sync pin not driven");
    a_hold_period: assert property (state_q == clk_sel_pkg::ST_LOCKED ##1
        state_q == clk_sel_pkg::ST_HOLD |-> hold_per_q == $past(lock_per_q))
        else $error("holdover period wrong");
    a_apb_answer: assert property (access |=> pready ##1 !pready)
        else $error("apb answer timing");
    c_lock: cover property (state_q == clk_sel_pkg::ST_DETECT ##1
        state_q == clk_sel_pkg::ST_LOCKED);
    c_hold: cover property (state_q == clk_sel_pkg::ST_LOCKED ##1 state_q == clk_sel_pkg::ST_HOLD);
    c_no_clock: cover property (state_q == clk_sel_pkg::ST_DETECT ##1
        state_q == clk_sel_pkg::ST_INTERNAL);
    c_bad_addr: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ==== sync_source.sv ====
// Far-side clock source that shares the sync line with the device.
`timescale 1ns/1ps
`default_nettype none
module sync_source (
    input  wire logic run,
    output logic      clk_out
);
    // The source is a separate board clock, so its phase is unrelated to pclk.
    // It stands still low between frames so a stopped source cannot look like a clock.
    initial
    begin
        clk_out = 1'b0;
        #137;
        forever
        begin
            if (run)
            begin
                #400 clk_out = ~clk_out;
            end
            else
            begin
                clk_out = 1'b0;
                @(run);
            end
        end
    end
endmodule
`default_nettype wire

// ==== switching_clock_select_tb_top.sv ====
// Self-checking testbench of the switching clock select.
`timescale 1ns/1ps
`default_nettype none
module switching_clock_select_tb_top;
    typedef struct packed { logic h; logic l; logic r; logic [4:0] c; logic [7:0] p; } row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, en_pin, cfg_h, cfg_l;
    logic sh, sl, sr, sync_out, sync_oe, sw_clk, freq_locked, run, src, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [4:0]  code;
    wire logic   sync_in;
    int num_errors, n_tests, cyc, i, j;
    row_t rows [5] = '{'{1'b0, 1'b1, 1'b0, 5'h00, 8'h32}, '{1'b0, 1'b0, 1'b0, 5'h00, 8'h19},
                       '{1'b1, 1'b0, 1'b0, 5'h00, 8'h0a}, '{1'b0, 1'b0, 1'b1, 5'h00, 8'h32},
                       '{1'b0, 1'b0, 1'b1, 5'h12, 8'h08}};
    // Only the device strapped as output may drive; the source is silent then.
    assign sync_in = sync_oe ? sync_out : src;
    sync_source u_src (.run(run), .clk_out(src));
    switching_clock_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .en_pin(en_pin), .cfg_high_sense(cfg_h), .cfg_low_sense(cfg_l),
        .sync_high_sense(sh), .sync_low_sense(sl), .sync_res_sense(sr), .sync_res_code(code),
        .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe), .sw_clk(sw_clk),
        .freq_locked(freq_locked));
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            $display("[FAIL] %s expected %h seen %h", n, x, g);
            num_errors++;
        end
    endtask
    // The master waits for pready with no assumed latency; the timeout ends a hang.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic boot(input logic h, input logic l, input logic s_h, input logic s_l,
                        input logic s_r, input logic [4:0] c);
        @(posedge pclk);
        presetn <= 1'b0;
        en_pin <= 1'b0;
        run <= 1'b0;
        {cfg_h, cfg_l, sh, sl, sr, code} <= {h, l, s_h, s_l, s_r, c};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask
    task automatic lock_run(input logic l);
        boot(1'b0, l, 1'b0, 1'b0, 1'b0, 5'h00);
        run <= 1'b1;
        repeat (20) @(posedge pclk);
        en_pin <= 1'b1;
        i = 0;
        while (freq_locked !== 1'b1 && i < 200)
        begin
            @(posedge pclk);
            i++;
        end
        chk("locked", 32'h1, {31'h0, freq_locked});
        apb(1'b0, 8'h0c, 32'h0);
        chk("frb lock", 32'h04e20008, r & 32'hffff00ff);
        run <= 1'b0;
        repeat (150) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0);
        chk("state hold", 32'h6, {29'h0, r[4:2]});
        apb(1'b0, 8'h0c, 32'h0);
        chk("hold period", 32'h08, {24'h0, r[7:0]});
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, en_pin, cfg_h, cfg_l, sh, sl, sr, run} = 11'h0;
        {paddr, pwdata, code} = 45'h0;
        boot(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
        apb(1'b0, 8'h04, 32'h0);
        chk("fset reset", 32'h0190, r);
        apb(1'b0, 8'h08, 32'h0);
        chk("stat reset", 32'h20, r);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        for (int k = 0; k < 5; k++)
        begin
            boot(1'b0, 1'b0, rows[k].h, rows[k].l, rows[k].r, rows[k].c);
            en_pin <= 1'b1;
            repeat (250) @(posedge pclk);
            apb(1'b0, 8'h0c, 32'h0);
            chk("static period", {24'h0, rows[k].p}, {24'h0, r[7:0]});
        end
        sr <= 1'b0;
        en_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        en_pin <= 1'b1;
        repeat (250) @(posedge pclk);
        apb(1'b0, 8'h0c, 32'h0);
        chk("no resample", 32'h08, {24'h0, r[7:0]});
        foreach (rows[k])
        begin
            if (k < 3)
            begin
                apb(1'b1, 8'h04, k == 0 ? 32'd810 : (k == 1 ? 32'd100 : 32'd2000));
                apb(1'b1, 8'h00, 32'h1);
                apb(1'b0, 8'h0c, 32'h0);
                j = k == 0 ? 32'd10 : (k == 1 ? 32'd40 : 32'd6);
                chk("prog n", j, {26'h0, r[13:8]});
                j = k == 0 ? 32'd13 : (k == 1 ? 32'd50 : 32'd8);
                chk("prog period", j, {24'h0, r[7:0]});
            end
        end
        lock_run(1'b0);
        lock_run(1'b1);
        boot(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
        en_pin <= 1'b1;
        repeat (250) @(posedge pclk);
        chk("drive out", 32'h1, {31'h0, sync_oe});
        chk("no lock out", 32'h0, {31'h0, freq_locked});
        apb(1'b0, 8'h0c, 32'h0);
        chk("out period", 32'h19, {24'h0, r[7:0]});
        i = 0;
        j = 0;
        repeat (50)
        begin
            @(posedge pclk);
            i += sync_out;
            j += sw_clk;
        end
        chk("out high", 32'd24, i);
        chk("sw high", 32'd24, j);
        test_done();
    end
endmodule
`default_nettype wire
